// *** design/timer16_pkg.sv ***
// Constants for the sixteen-bit timer source select and count block.
// Assumes an APB master on the system clock; pin and oscillator sources are synchronised inside.
// What this block does
// [RULE1] Clock codes 0-8 route pin, instruction, system, oscillators, reference clock.
// [RULE2] Clock codes 9-12 pick timer overflows, own reserved; 13-16 logic cells.
// [RULE3] Gate codes pick overflow, period timers, match, capture, pwm, comparators, cells.
// [RULE4] Gate code zero takes this instance's remapped gate pin.
// [RULE5] Gate codes 2,4,6 pick sibling overflows, own reserved; others reserved.
// [RULE6] Select registers bits 7 to 5 ignore writes and read zero.
// [RULE7] Low count register reads and writes counter bits 7 to 0.
// [RULE8] With wide access set, high count register is a holding byte moved with low byte access; otherwise it is counter bits 15 to 8.
// [RULE9] Count bytes are read/write and not initialised by any reset.
// [RULE10] Select fields clear on power-on reset, keep value on other resets.
// [RULE11] With wide access set, count pair moves as one sixteen-bit operation.
// [RULE12] Reserved clock or gate codes give a constant inactive source.
`default_nettype none
package timer16_pkg;
    localparam logic [7:0] ADDR_CLK_SEL = 8'h00;
    localparam logic [7:0] ADDR_GATE_SEL = 8'h04;
    localparam logic [7:0] ADDR_CNT_LO = 8'h08;
    localparam logic [7:0] ADDR_CNT_HI = 8'h0c;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_GATE_LVL = 8'h14;
    localparam int SEL_W = 5;
    localparam logic [4:0] SEL_RESET = 5'h00;
    localparam int CTRL_WIDE_BIT = 1;
    localparam int CTRL_ON_BIT = 0;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [4:0] CLK_PIN = 5'h00;
    localparam logic [4:0] CLK_INSTR = 5'h01;
    localparam logic [4:0] CLK_SYS = 5'h02;
    localparam logic [4:0] CLK_HIGH_OSC = 5'h03;
    localparam logic [4:0] CLK_LOW_OSC = 5'h04;
    localparam logic [4:0] CLK_MID_500K = 5'h05;
    localparam logic [4:0] CLK_MID_32K = 5'h06;
    localparam logic [4:0] CLK_SEC_OSC = 5'h07;
    localparam logic [4:0] CLK_REF = 5'h08;
    localparam logic [4:0] CLK_OVF_BASE = 5'h09;
    localparam logic [4:0] CLK_CELL_BASE = 5'h0d;
    localparam logic [4:0] CLK_LAST = 5'h10;
    localparam logic [4:0] GATE_PIN = 5'h00;
    localparam logic [4:0] GATE_T0_OVF = 5'h01;
    localparam logic [4:0] GATE_PER_BASE = 5'h03;
    localparam logic [4:0] GATE_MATCH = 5'h08;
    localparam logic [4:0] GATE_CAP_BASE = 5'h09;
    localparam logic [4:0] GATE_PWM_BASE = 5'h0d;
    localparam logic [4:0] GATE_OSC_OUT = 5'h13;
    localparam logic [4:0] GATE_CMP1 = 5'h14;
    localparam logic [4:0] GATE_CMP2 = 5'h15;
    localparam logic [4:0] GATE_ZERO_CROSS = 5'h16;
    localparam logic [4:0] GATE_CELL_BASE = 5'h17;
    localparam logic [4:0] GATE_SIB_BASE = 5'h02;
    localparam logic [1:0] INST_FIRST = 2'h1;
endpackage
`default_nettype wire

// *** design/timer16_sync.sv ***
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the input is asynchronous to clk_i.
`default_nettype none
module timer16_sync (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic async_i,
    output logic level_o
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= async_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Only a level held over two samples counts, filtering runt pulses
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_o <= 1'b0;
        end else if (s2 == s3) begin
            level_o <= s3;
        end
    end
endmodule
`default_nettype wire

// *** design/timer16_source_select.sv ***
// Sixteen-bit timer/counter: clock and gate source selection, count bytes.
// Assumes an APB master on clk_i; overflow/cell/capture inputs are on clk_i,
// pins and oscillator clocks are asynchronous and are synchronised here.
`default_nettype none
module timer16_source_select #(
    parameter logic [1:0] INSTANCE = timer16_pkg::INST_FIRST,
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic por_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic remapped_count_pin_i,
    input wire logic remapped_gate_pin_i,
    input wire logic high_internal_oscillator_i,
    input wire logic low_internal_oscillator_i,
    input wire logic mid_internal_oscillator_500k_i,
    input wire logic mid_internal_oscillator_32k_i,
    input wire logic secondary_oscillator_i,
    input wire logic reference_clock_out_i,
    input wire logic [3:0] timer_overflow_i,
    input wire logic [3:0] logic_cell_i,
    input wire logic [2:0] period_timer_output_i,
    input wire logic measurement_timer_match_i,
    input wire logic [3:0] capture_unit_output_i,
    input wire logic [3:0] pwm_unit_output_i,
    input wire logic oscillator_output_i,
    input wire logic comparator_one_output_i,
    input wire logic comparator_two_output_i,
    input wire logic zero_cross_output_i,
    output logic count_edge_o,
    output logic gate_level_o,
    output logic overflow_o
);
    import timer16_pkg::*;

    localparam int N_ASYNC = 8;

    logic [4:0] count_clock_select;
    logic [4:0] gate_source_select;
    logic [7:0] count_high_byte;
    logic [7:0] read_high_buf;
    logic [CNT_W-1:0] counter;
    logic [1:0] ctrl;
    logic [N_ASYNC-1:0] async_raw;
    logic [N_ASYNC-1:0] async_sync;
    logic instr_div;
    logic [1:0] instr_cnt;
    logic clk_src;
    logic clk_src_q;
    logic gate_src;
    logic next_count;
    logic [31:0] next_rdata;
    logic wr_en;
    logic rd_en;
    logic mapped;

    assign async_raw = {reference_clock_out_i, secondary_oscillator_i,
                        mid_internal_oscillator_32k_i,
                        mid_internal_oscillator_500k_i,
                        low_internal_oscillator_i,
                        high_internal_oscillator_i,
                        remapped_gate_pin_i, remapped_count_pin_i};

    genvar gi;
    generate
        for (gi = 0; gi < N_ASYNC; gi++) begin : g_sync
            timer16_sync u_sync (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .async_i(async_raw[gi]),
                .level_o(async_sync[gi])
            );
        end
    endgenerate

    // Own overflow code is reserved; sibling indices 1..3 map to codes
    function automatic logic sibling_ok(input logic [1:0] idx);
        sibling_ok = (idx != INSTANCE);
    endfunction

    // Instruction clock is the system clock divided by four
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            instr_cnt <= 2'h0;
        end else begin
            instr_cnt <= instr_cnt + 2'h1;
        end
    end
    assign instr_div = instr_cnt[1];

    always_comb begin
        clk_src = 1'b0; // RULE12
        case (count_clock_select)
            CLK_PIN: clk_src = async_sync[0]; // RULE1
            CLK_INSTR: clk_src = instr_div; // RULE1
            CLK_SYS: clk_src = instr_cnt[0]; // RULE1
            CLK_HIGH_OSC: clk_src = async_sync[2]; // RULE1
            CLK_LOW_OSC: clk_src = async_sync[3]; // RULE1
            CLK_MID_500K: clk_src = async_sync[4]; // RULE1
            CLK_MID_32K: clk_src = async_sync[5]; // RULE1
            CLK_SEC_OSC: clk_src = async_sync[6]; // RULE1
            CLK_REF: clk_src = async_sync[7]; // RULE1
            default: begin
                if (count_clock_select >= CLK_CELL_BASE &&
                    count_clock_select <= CLK_LAST) begin
                    clk_src = logic_cell_i[2'(count_clock_select
                                               - CLK_CELL_BASE)]; // RULE2
                end else if (count_clock_select >= CLK_OVF_BASE &&
                             count_clock_select < CLK_CELL_BASE) begin
                    if (count_clock_select == CLK_OVF_BASE ||
                        sibling_ok(2'(count_clock_select - CLK_OVF_BASE)))
                    begin
                        clk_src = timer_overflow_i[2'(count_clock_select
                                                      - CLK_OVF_BASE)]; // RULE2
                    end
                end
            end
        endcase
    end

    always_comb begin
        gate_src = 1'b0; // RULE12
        case (gate_source_select)
            GATE_PIN: gate_src = async_sync[1]; // RULE4
            GATE_T0_OVF: gate_src = timer_overflow_i[0]; // RULE3
            GATE_MATCH: gate_src = measurement_timer_match_i; // RULE3
            GATE_OSC_OUT: gate_src = oscillator_output_i; // RULE3
            GATE_CMP1: gate_src = comparator_one_output_i; // RULE3
            GATE_CMP2: gate_src = comparator_two_output_i; // RULE3
            GATE_ZERO_CROSS: gate_src = zero_cross_output_i; // RULE3
            5'h02, 5'h04, 5'h06: begin
                if (sibling_ok(2'(gate_source_select[2:1]))) begin
                    gate_src = timer_overflow_i[gate_source_select[2:1]]; // RULE5
                end
            end
            5'h03, 5'h05, 5'h07: begin
                gate_src = period_timer_output_i[2'(
                    (gate_source_select - GATE_PER_BASE) >> 1)]; // RULE3
            end
            default: begin
                if (gate_source_select >= GATE_CAP_BASE &&
                    gate_source_select < GATE_PWM_BASE) begin
                    gate_src = capture_unit_output_i[2'(gate_source_select
                                                        - GATE_CAP_BASE)]; // RULE3
                end else if (gate_source_select >= GATE_PWM_BASE &&
                             gate_source_select <= CLK_LAST) begin
                    gate_src = pwm_unit_output_i[2'(gate_source_select
                                                    - GATE_PWM_BASE)]; // RULE3
                end else if (gate_source_select >= GATE_CELL_BASE &&
                             gate_source_select <= GATE_CELL_BASE + 5'h03) begin
                    gate_src = logic_cell_i[2'(gate_source_select
                                               - GATE_CELL_BASE)]; // RULE3
                end
            end
        endcase
    end

    // APB: zero wait states; writes land at the access edge, while read data
    // and the high byte snapshot are taken together at the setup edge, so a
    // wide read never pairs bytes from two different counts
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && !penable_i && !pwrite_i; // RULE11

    // Select fields only clear on power-on reset, not on device reset
    always_ff @(posedge clk_i or negedge por_b_i) begin
        if (!por_b_i) begin
            count_clock_select <= SEL_RESET; // RULE10
            gate_source_select <= SEL_RESET; // RULE10
        end else if (wr_en && paddr_i == ADDR_CLK_SEL) begin
            count_clock_select <= pwdata_i[SEL_W-1:0]; // RULE6
        end else if (wr_en && paddr_i == ADDR_GATE_SEL) begin
            gate_source_select <= pwdata_i[SEL_W-1:0]; // RULE6
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl <= CTRL_RESET;
        end else if (wr_en && paddr_i == ADDR_CTRL) begin
            ctrl <= pwdata_i[1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_src_q <= 1'b0;
        end else begin
            clk_src_q <= clk_src;
        end
    end
    assign next_count = ctrl[CTRL_ON_BIT] && gate_src && clk_src && !clk_src_q;

    // Count bytes have no reset value; software must load them
    always_ff @(posedge clk_i) begin
        if (wr_en && paddr_i == ADDR_CNT_LO) begin
            if (ctrl[CTRL_WIDE_BIT]) begin
                counter <= {count_high_byte, pwdata_i[7:0]}; // RULE11
            end else begin
                counter[7:0] <= pwdata_i[7:0]; // RULE7
            end
        end else if (wr_en && paddr_i == ADDR_CNT_HI &&
                     !ctrl[CTRL_WIDE_BIT]) begin
            counter[CNT_W-1:8] <= pwdata_i[7:0]; // RULE9
        end else if (next_count) begin
            counter <= counter + CNT_W'(1);
        end
    end

    // Holding byte: written high byte waits for low write; low read latches high
    always_ff @(posedge clk_i) begin
        if (wr_en && paddr_i == ADDR_CNT_HI) begin
            count_high_byte <= pwdata_i[7:0]; // RULE8
        end
        if (rd_en && paddr_i == ADDR_CNT_LO) begin
            read_high_buf <= counter[CNT_W-1:8]; // RULE8
        end
    end

    always_comb begin
        mapped = 1'b1;
        next_rdata = 32'h0;
        case (paddr_i)
            ADDR_CLK_SEL: next_rdata = {27'h0, count_clock_select}; // RULE6
            ADDR_GATE_SEL: next_rdata = {27'h0, gate_source_select}; // RULE6
            ADDR_CNT_LO: next_rdata = {24'h0, counter[7:0]}; // RULE7
            ADDR_CNT_HI: next_rdata = {24'h0, ctrl[CTRL_WIDE_BIT] ?
                read_high_buf : counter[CNT_W-1:8]}; // RULE11
            ADDR_CTRL: next_rdata = {30'h0, ctrl};
            ADDR_GATE_LVL: next_rdata = {31'h0, gate_src};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !mapped;
            if (psel_i && !penable_i && !pwrite_i) begin
                prdata_o <= next_rdata;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_edge_o <= 1'b0;
            gate_level_o <= 1'b0;
            overflow_o <= 1'b0;
        end else begin
            count_edge_o <= next_count;
            gate_level_o <= gate_src;
            overflow_o <= next_count && (&counter);
        end
    end
endmodule
`default_nettype wire

// *** verification/timer16_asserts.sv ***
// Checker for the timer block: bus handshake and counter pulse relations.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module timer16_asserts
    import timer16_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic count_edge_o,
    input wire logic overflow_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic mapped;
    assign mapped = paddr_i <= ADDR_GATE_LVL && paddr_i[1:0] == 2'h0;
    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence sel_read_s;
        psel_i && penable_i && pready_o && !pwrite_i && paddr_i < ADDR_CNT_LO;
    endsequence
    answer_time_a: assert property (setup_s |=> pready_o)
        else $error("ready missing after setup");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    ready_cause_a: assert property (pready_o |-> $past(psel_i && !penable_i))
        else $error("ready without setup");
    unmapped_err_a: assert property (setup_s ##0 !mapped |=> pslverr_o)
        else $error("no error on unmapped address");
    mapped_ok_a: assert property (setup_s ##0 mapped |=> !pslverr_o)
        else $error("error on mapped address");
    sel_upper_a: assert property (sel_read_s |-> prdata_o[31:5] == 27'h0)
        else $error("select upper bits not zero");
    err_data_a: assert property (pready_o && pslverr_o && !pwrite_i |->
        prdata_o == 32'h0) else $error("refused read data not zero");
    edge_space_a: assert property (count_edge_o |=> !count_edge_o)
        else $error("count edges back to back");
    wrap_edge_a: assert property (overflow_o |-> count_edge_o)
        else $error("wrap without edge");
endmodule
bind timer16_source_select timer16_asserts u_asserts (.clk_i, .rst_b_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o,
    .pslverr_o, .count_edge_o, .overflow_o);
`default_nettype wire

// *** verification/timer16_source_select_tb_top.sv ***
// Testbench: drives the timer block over the register bus and its sources.
// Assumes one clock; a monitor checks queued read results at each answer.
`default_nettype none
module timer16_source_select_tb_top import timer16_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_b_i = 0, por_b_i = 0, src = 0;
    logic psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic pready_o, pslverr_o, count_edge_o, gate_level_o, overflow_o;
    logic [3:0] timer_overflow_i = 0, logic_cell_i = 0;
    logic [3:0] capture_unit_output_i = 0, pwm_unit_output_i = 0;
    logic [2:0] period_timer_output_i = 0;
    logic remapped_gate_pin_i = 0, measurement_timer_match_i = 0;
    logic oscillator_output_i = 0, zero_cross_output_i = 0;
    logic comparator_one_output_i = 0, comparator_two_output_i = 0;
    logic [33:0] q[$];
    logic [33:0] e;
    int fails = 0, compares = 0, edges = 0, wraps = 0;
    timer16_source_select u_dut (
        .clk_i, .rst_b_i, .por_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .remapped_count_pin_i(src),
        .remapped_gate_pin_i, .high_internal_oscillator_i(src),
        .low_internal_oscillator_i(src), .mid_internal_oscillator_500k_i(src),
        .mid_internal_oscillator_32k_i(src), .secondary_oscillator_i(src),
        .reference_clock_out_i(src), .timer_overflow_i, .logic_cell_i,
        .period_timer_output_i, .measurement_timer_match_i,
        .capture_unit_output_i, .pwm_unit_output_i, .oscillator_output_i,
        .comparator_one_output_i, .comparator_two_output_i,
        .zero_cross_output_i, .count_edge_o, .gate_level_o, .overflow_o);
    always #20 clk_i = ~clk_i;
    task check(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            fails++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // Monitor samples between edges, so it never races the bus driver
    always @(negedge clk_i) begin
        edges += (count_edge_o === 1'b1);
        wraps += (overflow_o === 1'b1);
        if (psel_i && penable_i && pready_o === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            check(pslverr_o === e[32] && (!e[33] || prdata_o === e[31:0]),
                "bus answer");
        end
    end
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic c, input logic er);
        @(posedge clk_i);
        q.push_back({c, er, d});
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // Ready is sampled at rising edges; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        check(pslverr_o === er, "answer flag");
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, d, 1'b1, 1'b0);
    endtask
    // Pin, oscillator, reference, overflow and cell sources move together; selection decides which one counts
    task pulses(input int n);
        repeat (n) begin
            @(posedge clk_i);
            src <= 1'b1;
            timer_overflow_i <= 4'hf;
            logic_cell_i <= 4'hf;
            repeat (8) @(posedge clk_i);
            src <= 1'b0;
            timer_overflow_i <= 4'h0;
            logic_cell_i <= 4'h0;
            repeat (8) @(posedge clk_i);
        end
    endtask
    function automatic logic gexp(input logic [4:0] c);
        case (c)
            5'h00: return remapped_gate_pin_i;
            5'h01: return timer_overflow_i[0];
            5'h04: return timer_overflow_i[2];
            5'h06: return timer_overflow_i[3];
            5'h03, 5'h05, 5'h07: return period_timer_output_i[(c - 3) / 2];
            5'h08: return measurement_timer_match_i;
            5'h13: return oscillator_output_i;
            5'h14: return comparator_one_output_i;
            5'h15: return comparator_two_output_i;
            5'h16: return zero_cross_output_i;
            default: ;
        endcase
        if (c >= 5'h09 && c <= 5'h0c) return capture_unit_output_i[c - 9];
        if (c >= 5'h0d && c <= 5'h10) return pwm_unit_output_i[c - 13];
        if (c >= 5'h17 && c <= 5'h1a) return logic_cell_i[c - 23];
        return 1'b0;
    endfunction
    task stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        stop_test;
    end
    initial begin
        int lo;
        logic [7:0] r;
        void'($urandom(66));
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        por_b_i <= 1'b1;
        rd(ADDR_CLK_SEL, 32'h0);
        rd(ADDR_GATE_SEL, 32'h0);
        wr(ADDR_CLK_SEL, 32'hffff_ffff);
        wr(ADDR_GATE_SEL, 32'hffff_ffea);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(ADDR_CLK_SEL, 32'h1f);
        rd(ADDR_GATE_SEL, 32'h0a);
        apb(1'b0, 8'h18, 32'h0, 1'b1, 1'b1);
        apb(1'b1, 8'h40, 32'h5, 1'b0, 1'b1);
        r = 8'($urandom);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CNT_LO, {24'h0, r});
        wr(ADDR_CNT_HI, 32'h77);
        rd(ADDR_CNT_LO, {24'h0, r});
        rd(ADDR_CNT_HI, 32'h77);
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_CNT_HI, 32'ha5);
        wr(ADDR_CNT_LO, 32'h3c);
        rd(ADDR_CNT_LO, 32'h3c);
        rd(ADDR_CNT_HI, 32'ha5);
        wr(ADDR_CNT_HI, 32'hff);
        wr(ADDR_CNT_LO, 32'hff);
        measurement_timer_match_i <= 1'b1;
        wr(ADDR_GATE_SEL, 32'h08);
        wr(ADDR_CLK_SEL, 32'h0d);
        wr(ADDR_CTRL, 32'h3);
        edges = 0;
        pulses(1);
        check(edges == 1 && wraps == 1, "wrap");
        rd(ADDR_CNT_LO, 32'h0);
        rd(ADDR_CNT_HI, 32'h0);
        for (int c = 0; c < 18; c++) begin
            wr(ADDR_CLK_SEL, c);
            edges = 0;
            lo = (c == 1) ? 8 : 18;
            if (c == 1 || c == 2) begin
                repeat (40) @(posedge clk_i);
                check(edges >= lo && edges <= lo + 4, "free clock");
            end else begin
                pulses(3);
                lo = (c == 10 || c > 16) ? 0 : 3;
                check(edges == lo, "source edges");
            end
        end
        for (int c = 0; c < 32; c++) begin
            {remapped_gate_pin_i, timer_overflow_i, period_timer_output_i,
             measurement_timer_match_i, capture_unit_output_i,
             pwm_unit_output_i, oscillator_output_i, comparator_one_output_i,
             comparator_two_output_i, zero_cross_output_i,
             logic_cell_i} <= 25'($urandom);
            wr(ADDR_GATE_SEL, c);
            repeat (8) @(posedge clk_i);
            @(negedge clk_i);
            check(gate_level_o === gexp(5'(c)), "gate level");
            rd(ADDR_GATE_LVL, {31'h0, gexp(5'(c))});
        end
        stop_test;
    end
endmodule
`default_nettype wire
